// *** pkg/rh_status_pkg.sv ***
package rh_status_pkg;

    // command codes on the shared microprocessor bus
    localparam logic [7:0] CMD_READ_STATUS  = 8'h14;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h94;

    // bit positions in root_hub_global_status
    localparam int CLEAR_WAKE_BIT   = 31;
    localparam int OC_CHANGE_BIT    = 17;
    localparam int SET_POWER_BIT    = 16;
    localparam int WAKE_ENABLE_BIT  = 15;
    localparam int GLOBAL_OC_BIT    = 1;
    localparam int CLEAR_POWER_BIT  = 0;

    localparam logic [31:0] STATUS_RESET = 32'h00000000;
    localparam int          NUM_PORTS    = 2;

    // one bus access as seen by the register bank
    typedef struct packed {
        logic        valid;
        logic [7:0]  cmd;
        logic [31:0] wdata;
    } bus_req_s;

endpackage

// *** hw/root_hub_global_status_reg.sv ***
`timescale 1ns/1ns
// Function
// - read with command 14 hex, write with command 94 hex.
// - lower half holds hub status, upper half holds status change flags.
// - writing one to bit 31 clears remote wake enable.
// - writing one to bit 15 sets wake enable; read shows its state.
// - with wake enable, connect change resumes from suspend and raises interrupt.
// - hardware sets bit 17 whenever the global overcurrent bit changes.
// - writing one to bit 17 clears the overcurrent change flag.
// - bit 1 reads one during overcurrent when reporting is global.
// - bit 1 is held zero when overcurrent is reported per port.
// - bits 16 and 0 read zero; writes to them are power commands.
// - global mode: writing one to bit 16 powers all ports on.
// - per-port mode: bit 16 powers on only unmasked ports.
// - global mode: writing one to bit 0 powers all ports off.
// - per-port mode: bit 0 powers off only unmasked ports.
// - power mask bit n exempts port n; bit 0 reserved.
module root_hub_global_status_reg
    import rh_status_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // microprocessor bus
    input  wire bus_req_s         bus_req,
    output logic [31:0]           rdata,
    output logic                  rdata_valid,
    // configuration and port signals
    input  wire logic             power_switch_scheme,
    input  wire logic             per_port_oc_mode,
    input  wire logic [PORTS:0]   per_port_power_mask,
    input  wire logic [PORTS:0]   port_connect_changed,
    input  wire logic             overcurrent_pin,
    input  wire logic             suspended_state,
    // outputs
    output logic [PORTS:1]        port_power_on_state,
    output logic                  resume_seen_interrupt,
    output logic                  resuming_state
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisation: overcurrent pin is asynchronous
    logic oc_meta;
    logic oc_sync;
    logic next_oc_meta;
    logic next_oc_sync;

    always_comb begin
        next_oc_meta = overcurrent_pin;
        next_oc_sync = oc_meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oc_meta <= 1'b0;
            oc_sync <= 1'b0;
        end else begin
            oc_meta <= next_oc_meta;
            oc_sync <= next_oc_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic             remote_wake_enable;
    logic             overcurrent_change_flag;
    logic             global_overcurrent_flag;
    logic [PORTS:1]   next_power;
    logic             next_wake;
    logic             next_oc_change;
    logic             next_global_oc;
    logic             next_resume_irq;
    logic             next_resuming;
    logic [31:0]      next_rdata;
    logic             next_rdata_valid;
    logic             wr;
    logic             rd;
    logic             set_global_power_cmd;
    logic             clear_global_power_cmd;
    logic             clear_wake_enable_cmd;
    logic             any_connect;

    always_comb begin
        // reserved write bits are ignored, software keeps them zero
        wr = bus_req.valid && (bus_req.cmd == CMD_WRITE_STATUS);
        rd = bus_req.valid && (bus_req.cmd == CMD_READ_STATUS);
        set_global_power_cmd   = wr && bus_req.wdata[SET_POWER_BIT];
        clear_global_power_cmd = wr && bus_req.wdata[CLEAR_POWER_BIT];
        clear_wake_enable_cmd  = wr && bus_req.wdata[CLEAR_WAKE_BIT];
        any_connect = |port_connect_changed[PORTS:1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // remote wake enable
    always_comb begin
        // set wins if both are written in one access
        next_wake = remote_wake_enable;
        if (clear_wake_enable_cmd) begin
            next_wake = 1'b0;
        end
        if (wr && bus_req.wdata[WAKE_ENABLE_BIT]) begin
            next_wake = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remote_wake_enable <= 1'b0;
        end else begin
            remote_wake_enable <= next_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // overcurrent indicator and its change flag
    always_comb begin
        next_global_oc = per_port_oc_mode ? 1'b0 : oc_sync;

        // hardware change wins over a clear in the same cycle
        next_oc_change = overcurrent_change_flag;
        if (wr && bus_req.wdata[OC_CHANGE_BIT]) begin
            next_oc_change = 1'b0;
        end
        if (next_global_oc != global_overcurrent_flag) begin
            next_oc_change = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overcurrent_change_flag <= 1'b0;
            global_overcurrent_flag <= 1'b0;
        end else begin
            overcurrent_change_flag <= next_oc_change;
            global_overcurrent_flag <= next_global_oc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // downstream port power
    always_comb begin
        // clear wins over set if software writes both at once
        next_power = port_power_on_state;
        for (int p = 1; p <= PORTS; p++) begin
            if (!power_switch_scheme || !per_port_power_mask[p]) begin
                if (set_global_power_cmd) begin
                    next_power[p] = 1'b1;
                end
                if (clear_global_power_cmd) begin
                    next_power[p] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_power_on_state <= '0;
        end else begin
            port_power_on_state <= next_power;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // resume detection
    always_comb begin
        // wake-up only counts while suspended and enabled
        next_resume_irq = resume_seen_interrupt;
        next_resuming   = resuming_state;
        if (remote_wake_enable && any_connect && suspended_state) begin
            next_resume_irq = 1'b1;
            next_resuming   = 1'b1;
        end else if (!suspended_state) begin
            next_resuming   = 1'b0;
        end
        if (!suspended_state && !resuming_state) begin
            next_resume_irq = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resume_seen_interrupt <= 1'b0;
            resuming_state        <= 1'b0;
        end else begin
            resume_seen_interrupt <= next_resume_irq;
            resuming_state        <= next_resuming;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        // unimplemented and write-only bits read zero
        next_rdata = STATUS_RESET;
        next_rdata[OC_CHANGE_BIT]   = overcurrent_change_flag;
        next_rdata[WAKE_ENABLE_BIT] = remote_wake_enable;
        next_rdata[GLOBAL_OC_BIT]   = global_overcurrent_flag;
        if (!rd) begin
            next_rdata = rdata;
        end
        next_rdata_valid = rd;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata       <= STATUS_RESET;
            rdata_valid <= 1'b0;
        end else begin
            rdata       <= next_rdata;
            rdata_valid <= next_rdata_valid;
        end
    end

endmodule

// *** tb/rh_status_checker.sv ***
`timescale 1ns/1ns
module rh_status_checker
    import rh_status_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    // clock, reset and bus
    input wire logic           clk,
    input wire logic           rst,
    input wire bus_req_s       bus_req,
    input wire logic [31:0]    rdata,
    input wire logic           rdata_valid,
    // configuration and ports
    input wire logic           power_switch_scheme,
    input wire logic           per_port_oc_mode,
    input wire logic [PORTS:0] per_port_power_mask,
    input wire logic [PORTS:0] port_connect_changed,
    input wire logic           overcurrent_pin,
    input wire logic           suspended_state,
    input wire logic [PORTS:1] port_power_on_state,
    input wire logic           resume_seen_interrupt,
    input wire logic           resuming_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire rq = bus_req.valid && bus_req.cmd == CMD_READ_STATUS;
    wire wq = bus_req.valid && bus_req.cmd == CMD_WRITE_STATUS;
    wire [31:0] wd = bus_req.wdata;
    rd_answer_a: assert property (rq |=> rdata_valid)
        else $error("read not answered");
    no_answer_a: assert property (!rq |=> !rdata_valid)
        else $error("answer without read");
    rdata_hold_a: assert property (!rq |=> $stable(rdata))
        else $error("read data moved without read");
    power_on_a: assert property (wq && wd[16] && !wd[0] && !power_switch_scheme
        |=> &port_power_on_state) else $error("ports not powered");
    power_off_a: assert property (wq && wd[0] && !power_switch_scheme
        |=> port_power_on_state == '0) else $error("ports not off");
    mask_kept_a: assert property (wq && power_switch_scheme
        |=> ((port_power_on_state ^ $past(port_power_on_state))
        & $past(per_port_power_mask[PORTS:1])) == '0)
        else $error("masked port changed");
    read_zero_a: assert property (rdata_valid |-> (rdata & 32'hFFFD7FFD) == 32'h0)
        else $error("reserved bit read one");
    oc_local_a: assert property (rdata_valid && per_port_oc_mode |-> !rdata[1])
        else $error("global overcurrent set");
    wake_cause_a: assert property ($rose(resuming_state) |-> resume_seen_interrupt
        && $past(suspended_state && |port_connect_changed[PORTS:1]))
        else $error("resume without cause");
endmodule
bind root_hub_global_status_reg rh_status_checker #(.PORTS(PORTS)) chk (
    .clk                   (clk),
    .rst                   (rst),
    .bus_req               (bus_req),
    .rdata                 (rdata),
    .rdata_valid           (rdata_valid),
    .power_switch_scheme   (power_switch_scheme),
    .per_port_oc_mode      (per_port_oc_mode),
    .per_port_power_mask   (per_port_power_mask),
    .port_connect_changed  (port_connect_changed),
    .overcurrent_pin       (overcurrent_pin),
    .suspended_state       (suspended_state),
    .port_power_on_state   (port_power_on_state),
    .resume_seen_interrupt (resume_seen_interrupt),
    .resuming_state        (resuming_state)
);

// *** tb/rh_host.sv ***
`timescale 1ns/1ns
module rh_host
    import rh_status_pkg::*;
(
    input wire logic        clk,
    output bus_req_s        req,
    input wire logic [31:0] rdata,
    input wire logic        rdata_valid
);
    initial req = '0;
    // released lines are inverted so stale values never look valid
    task wr(input logic [31:0] d);
        @(posedge clk) #1 req = {1'b1, CMD_WRITE_STATUS, d & 32'h80038001};
        @(posedge clk) #1 req = ~req;
    endtask
    task rd(output logic [31:0] d, output bit ok);
        @(posedge clk) #1 req = {1'b1, CMD_READ_STATUS, 32'h0};
        @(posedge clk) #1 req = ~req;
        ok = rdata_valid;
        d = rdata;
    endtask
endmodule

// *** tb/root_hub_global_status_reg_tb.sv ***
`timescale 1ns/1ns
module root_hub_global_status_reg_tb;
    import rh_status_pkg::*;
    logic clk = 0, rst = 1, sch = 0, ocm = 0, ocp = 0, susp = 0, rv, irq, resm;
    logic [2:0] mask = '0, conn = '0;
    logic [2:1] pwr;
    logic [31:0] rdata;
    bus_req_s req;
    int err_count = 0, cmp_count = 0;
    always #5 clk = ~clk;
    root_hub_global_status_reg dut (.clk(clk), .rst(rst), .bus_req(req), .rdata(rdata),
        .rdata_valid(rv), .power_switch_scheme(sch), .per_port_oc_mode(ocm),
        .per_port_power_mask(mask), .port_connect_changed(conn), .overcurrent_pin(ocp),
        .suspended_state(susp), .port_power_on_state(pwr), .resume_seen_interrupt(irq),
        .resuming_state(resm));
    rh_host host (.clk(clk), .req(req), .rdata(rdata), .rdata_valid(rv));
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s exp %h got %h", n, e, s);
        end
    endtask
    task rdc(input logic [31:0] e);
        logic [31:0] v;
        bit ok;
        host.rd(v, ok);
        chk("read valid", 32'(ok), 32'h1);
        chk("status", v, e);
    endtask
    task pw(input logic [2:0] m, input logic [31:0] d, input logic [1:0] e);
        mask = m;
        host.wr(d);
        chk("power", 32'(pwr), 32'(e));
    endtask
    task wake(input logic e);
        conn = 3'h2;
        @(posedge clk) #1 conn = 3'h0;
        chk("resume", 32'({resm, irq}), {30'h0, e, e});
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        summarize;
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rst = 0;
        rdc(32'h0);
        host.wr(32'h8000);
        rdc(32'h8000);
        host.wr(32'h80000000);
        rdc(32'h0);
        susp = 1;
        wake(1'b0);
        host.wr(32'h8000);
        wake(1'b1);
        susp = 0;
        $display("wake test done");
        pw(3'h6, 32'h10000, 2'h3);
        rdc(32'h8000);
        pw(3'h6, 32'h1, 2'h0);
        sch = 1;
        pw(3'h4, 32'h10000, 2'h1);
        pw(3'h0, 32'h10000, 2'h3);
        pw(3'h2, 32'h1, 2'h1);
        $display("power test done");
        ocp = 1;
        repeat (4) @(posedge clk);
        rdc(32'h28002);
        host.wr(32'h20000);
        rdc(32'h8002);
        ocp = 0;
        repeat (4) @(posedge clk);
        rdc(32'h28000);
        host.wr(32'h20000);
        ocm = 1;
        ocp = 1;
        repeat (4) @(posedge clk);
        rdc(32'h8000);
        $display("overcurrent test done");
        summarize;
    end
endmodule
